// ---- logic/mtc_turn_counter.sv ----
// Functional notes
// - Usage setting: 0 absolute (default), 1 incremental; applied on restart only.
// - Absolute selected with incremental encoder raises an alarm at first power-up.
// - Alarm reset clears alarm one only if the encoder is not incremental; turn count reset clears alarm two after battery swap.
// - Turn limit 0..65535, default 10, applied on restart, absolute mode only.
// - Limit other than 0 or default: reverse turn at count 0 loads limit minus one.
// - Limit other than 0 or default: forward turn at limit minus one sets count 0.
// - Count held at 0 for single-turn encoder or incremental usage.
// - Turn limit also seen as object entry 30A9h.
`timescale 1ns/100ps
`default_nettype none
`include "mtc_consts.svh"
module mtc_turn_counter #(
    parameter int POS_W = 17
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [3:0]       addr,
    input  wire logic [15:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [15:0]      rdata,
    input  wire logic [POS_W-1:0] enc_pos,
    input  wire logic             enc_pos_valid,
    input  wire logic             enc_is_incremental,
    input  wire logic             enc_single_turn,
    input  wire logic             battery_low,
    output logic      [15:0]      turn_count,
    output logic                  encoder_alarm_one,
    output logic                  encoder_alarm_two
);
    // Pin synchronisers for the encoder strap and battery lines
    logic [2:0] inc_sync;
    logic [2:0] single_sync;
    logic [2:0] batt_sync;
    logic       enc_inc;
    logic       enc_single;
    logic       batt_low;

    // Settings as written and as applied after restart
    logic        encoder_usage_select;
    logic [15:0] turn_wrap_limit;
    logic        usage_live;
    logic [15:0] limit_live;
    logic        restart_req;
    mtc_pkg::mtc_boot_t boot;

    logic        rev_fwd;
    logic        rev_rev;
    logic        hold_zero;
    logic        wrap_on;
    logic [15:0] limit_m1;
    logic        first_check;
    logic [1:0]  settle_cnt;

    // Write decode shared by the command bits
    function automatic logic cmd_hit(input logic [3:0] a, input logic w,
                                     input logic [15:0] d, input int b);
        cmd_hit = w && a == `MTC_OFS_CMD && d[b];
    endfunction

    // Three stage synchronisers, change seen once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inc_sync    <= 3'h0;
            single_sync <= 3'h0;
            batt_sync   <= 3'h0;
            enc_inc     <= 1'b0;
            enc_single  <= 1'b0;
            batt_low    <= 1'b0;
        end else if (ce) begin
            inc_sync    <= {inc_sync[1:0], enc_is_incremental};
            single_sync <= {single_sync[1:0], enc_single_turn};
            batt_sync   <= {batt_sync[1:0], battery_low};
            if (inc_sync[1] == inc_sync[2]) begin
                enc_inc <= inc_sync[2];
            end
            if (single_sync[1] == single_sync[2]) begin
                enc_single <= single_sync[2];
            end
            if (batt_sync[1] == batt_sync[2]) begin
                batt_low <= batt_sync[2];
            end
        end
    end

    mtc_wrap_detect #(
        .POS_W     (POS_W)
    ) u_wrap (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .pos       (enc_pos),
        .pos_valid (enc_pos_valid),
        .rev_fwd   (rev_fwd),
        .rev_rev   (rev_rev)
    );

    // Software side settings, stored immediately
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            encoder_usage_select <= `MTC_USAGE_RESET;
            turn_wrap_limit      <= `MTC_LIMIT_RESET;
        end else if (ce && wr) begin
            if (addr == `MTC_OFS_USAGE) begin
                encoder_usage_select <= wdata[`MTC_USAGE_BIT];
            end
            if (addr == `MTC_OFS_LIMIT) begin
                turn_wrap_limit <= wdata;
            end
        end
    end

    // Restart request pulse from the command register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_req <= 1'b0;
        end else if (ce) begin
            restart_req <= cmd_hit(addr, wr, wdata, `MTC_CMD_RESTART);
        end
    end

    // Cycles spent in the check stage; synchronisers are cleared by reset,
    // so the strap pins are only trustworthy after a few edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt <= 2'h0;
        end else if (ce) begin
            if (boot == mtc_pkg::mtc_boot_t_check) begin
                settle_cnt <= settle_cnt + 2'h1;
            end else begin
                settle_cnt <= 2'h0;
            end
        end
    end

    // Restart sequence: apply settings, then let straps settle, then check
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot        <= mtc_pkg::mtc_boot_t_idle;
            usage_live  <= `MTC_USAGE_RESET;
            limit_live  <= `MTC_LIMIT_RESET;
            first_check <= 1'b0;
        end else if (ce) begin
            first_check <= 1'b0;
            unique case (boot)
                mtc_pkg::mtc_boot_t_idle: begin
                    usage_live <= encoder_usage_select;
                    limit_live <= turn_wrap_limit;
                    boot       <= mtc_pkg::mtc_boot_t_check;
                end
                mtc_pkg::mtc_boot_t_check: begin
                    // Judge the encoder type only once the synced strap is valid
                    if (settle_cnt == `MTC_SETTLE_LAST) begin
                        first_check <= 1'b1;
                        boot        <= mtc_pkg::mtc_boot_t_run;
                    end
                end
                mtc_pkg::mtc_boot_t_run: begin
                    if (restart_req) begin
                        boot <= mtc_pkg::mtc_boot_t_idle;
                    end
                end
                default: begin
                    boot <= mtc_pkg::mtc_boot_t_idle;
                end
            endcase
        end
    end

    // Alarm one on type mismatch at power-up, alarm two on battery loss
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            encoder_alarm_one <= 1'b0;
            encoder_alarm_two <= 1'b0;
        end else if (ce) begin
            if (first_check && usage_live == `MTC_USE_ABSOLUTE && enc_inc) begin
                encoder_alarm_one <= 1'b1;
            end else if (first_check && usage_live == `MTC_USE_INCREMENT) begin
                encoder_alarm_one <= 1'b0;
            end else if (cmd_hit(addr, wr, wdata, `MTC_CMD_ALM_RESET) && !enc_inc) begin
                encoder_alarm_one <= 1'b0;
            end
            if (batt_low && usage_live == `MTC_USE_ABSOLUTE) begin
                encoder_alarm_two <= 1'b1; // set wins over clear
            end else if (cmd_hit(addr, wr, wdata, `MTC_CMD_TURN_RESET)) begin
                encoder_alarm_two <= 1'b0;
            end
        end
    end

    // Counter modes derived from applied settings
    assign hold_zero = usage_live == `MTC_USE_INCREMENT || enc_single;
    assign wrap_on   = limit_live != `MTC_LIMIT_RESET && limit_live != 16'h0000;
    assign limit_m1  = limit_live - 16'h0001;

    // Multiturn count with optional wrap at the limit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            turn_count <= 16'h0000;
        end else if (ce) begin
            if (hold_zero || boot != mtc_pkg::mtc_boot_t_run) begin
                turn_count <= 16'h0000;
            end else if (cmd_hit(addr, wr, wdata, `MTC_CMD_TURN_RESET)) begin
                turn_count <= 16'h0000;
            end else if (rev_fwd) begin
                if (wrap_on && turn_count == limit_m1) begin
                    turn_count <= 16'h0000;
                end else begin
                    turn_count <= turn_count + 16'h0001;
                end
            end else if (rev_rev) begin
                if (wrap_on && turn_count == 16'h0000) begin
                    turn_count <= limit_m1;
                end else begin
                    turn_count <= turn_count - 16'h0001;
                end
            end
        end
    end

    // Read data stands one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            rdata <= 16'h0000;
            if (rd) begin
                unique case (addr)
                    `MTC_OFS_USAGE:     rdata <= {15'h0000, encoder_usage_select};
                    `MTC_OFS_LIMIT:     rdata <= turn_wrap_limit;
                    `MTC_OFS_STATUS:    rdata <= {11'h000, enc_inc, enc_single, usage_live,
                                                  encoder_alarm_two, encoder_alarm_one};
                    `MTC_OFS_COUNT:     rdata <= turn_count;
                    `MTC_OFS_OBJ_INDEX: rdata <= `MTC_OBJ_INDEX;
                    default:            rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // mtc_turn_counter
`default_nettype wire

// ---- pkg/mtc_consts.svh ----
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH

// Register offsets (word addresses on the plain port)
`define MTC_OFS_USAGE      4'h0
`define MTC_OFS_LIMIT      4'h1
`define MTC_OFS_CMD        4'h2
`define MTC_OFS_STATUS     4'h3
`define MTC_OFS_COUNT      4'h4
`define MTC_OFS_OBJ_INDEX  4'h5

// Field positions
`define MTC_USAGE_BIT      0
`define MTC_CMD_RESTART    0
`define MTC_CMD_ALM_RESET  1
`define MTC_CMD_TURN_RESET 2
`define MTC_ST_ALARM_ONE   0
`define MTC_ST_ALARM_TWO   1
`define MTC_ST_USAGE       2
`define MTC_ST_SINGLE      3
`define MTC_ST_ENC_INCR    4

// Reset values
`define MTC_USAGE_RESET    1'h0
`define MTC_LIMIT_RESET    16'h000a
`define MTC_OBJ_INDEX      16'h30a9

// Last settle cycle of the power-up check; the strap synchronisers need four edges
`define MTC_SETTLE_LAST    2'h2

// Encoder usage codes
`define MTC_USE_ABSOLUTE   1'h0
`define MTC_USE_INCREMENT  1'h1

`endif

// ---- pkg/mtc_pkg.sv ----
`default_nettype none
package mtc_pkg;
    // Stage of the power-up check
    typedef enum logic [1:0] {
        mtc_boot_t_idle  = 2'b00,
        mtc_boot_t_check = 2'b01,
        mtc_boot_t_run   = 2'b10
    } mtc_boot_t;

    // Direction of one revolution event
    typedef enum logic [1:0] {
        mtc_dir_none = 2'b00,
        mtc_dir_fwd  = 2'b01,
        mtc_dir_rev  = 2'b10
    } mtc_dir_t;
endpackage
`default_nettype wire

// ---- logic/mtc_wrap_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
// Finds single-turn position wrap and reports one revolution per pulse
module mtc_wrap_detect #(
    parameter int POS_W = 17
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [POS_W-1:0] pos,
    input  wire logic             pos_valid,
    output logic                  rev_fwd,
    output logic                  rev_rev
);
    logic [POS_W-1:0] last_pos;
    logic             have_last;
    logic [1:0]       quad_now;
    logic [1:0]       quad_last;

    // Top two bits give the quadrant of the shaft
    assign quad_now  = pos[POS_W-1 -: 2];
    assign quad_last = last_pos[POS_W-1 -: 2];

    // Keep the previous sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_pos  <= '0;
            have_last <= 1'b0;
        end else if (ce && pos_valid) begin
            last_pos  <= pos;
            have_last <= 1'b1;
        end
    end

    // Quadrant 3 to 0 is a forward wrap, 0 to 3 a reverse one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rev_fwd <= 1'b0;
            rev_rev <= 1'b0;
        end else if (ce) begin
            rev_fwd <= pos_valid && have_last && quad_last == 2'h3 && quad_now == 2'h0;
            rev_rev <= pos_valid && have_last && quad_last == 2'h0 && quad_now == 2'h3;
        end
    end
endmodule // mtc_wrap_detect
`default_nettype wire

// ---- tb/mtc_turn_counter_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module mtc_turn_counter_chk #(
    parameter int POS_W = 17
) (
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic [3:0]       addr,
    input wire logic             rd,
    input wire logic [15:0]      rdata,
    input wire logic [POS_W-1:0] enc_pos,
    input wire logic             enc_pos_valid,
    input wire logic             enc_single_turn,
    input wire logic             battery_low,
    input wire logic [15:0]      turn_count,
    input wire logic             encoder_alarm_one,
    input wire logic             encoder_alarm_two
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [1:0] last_top;
    logic       fwd_w;
    logic       rev_w;
    // Quadrant of the last valid position sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) last_top <= 2'h0;
        else if (enc_pos_valid) last_top <= enc_pos[POS_W-1 -: 2];
    end
    // Revolution events as the counter should see them
    assign fwd_w = enc_pos_valid && last_top == 2'h3 && enc_pos[POS_W-1 -: 2] == 2'h0;
    assign rev_w = enc_pos_valid && last_top == 2'h0 && enc_pos[POS_W-1 -: 2] == 2'h3;
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0) else $error("read data without read");
    a_obj_index: assert property (rd && addr == 4'h5 |=> rdata == 16'h30a9) else $error("index");
    a_unmapped_zero: assert property (rd && addr > 4'h5 |=> rdata == 16'h0) else $error("unmapped");
    a_count_read: assert property (rd && addr == 4'h4 |=> rdata == $past(turn_count)) else $error("count");
    a_status_alarm: assert property (rd && addr == 4'h3 |=>
        rdata[1:0] == {$past(encoder_alarm_two), $past(encoder_alarm_one)}) else $error("status");
    a_fwd_step: assert property (fwd_w && turn_count != 16'h0 |-> ##2
        (turn_count == $past(turn_count, 2) + 16'h1 || turn_count == 16'h0)) else $error("forward step");
    a_rev_step: assert property (rev_w && turn_count != 16'h0 |-> ##2
        turn_count == $past(turn_count, 2) - 16'h1) else $error("reverse step");
    a_single_zero: assert property (enc_single_turn [*8] |-> turn_count == 16'h0) else $error("single");
    a_battery_alarm: assert property (battery_low [*6] |-> encoder_alarm_two) else $error("battery");
    c_fwd_wrap: cover property (fwd_w ##2 turn_count == 16'h0);
    c_rev_wrap: cover property (rev_w);
    c_alarm_one: cover property ($rose(encoder_alarm_one));
endmodule // mtc_turn_counter_chk
`default_nettype wire

// ---- tb/mtc_enc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mtc_enc_model #(
    parameter int POS_W = 17
) (
    input  wire logic             clk,
    output wire logic [POS_W-1:0] enc_pos,
    output var logic              enc_pos_valid
);
    logic [1:0]       q = 2'h0;
    logic [POS_W-3:0] cnt = '0;
    initial enc_pos_valid = 1'b0;
    // Free running pattern so stale position is never mistaken for a sample
    always @(posedge clk) cnt <= cnt + 1'b1;
    assign enc_pos = enc_pos_valid ? {q, {(POS_W-2){1'b0}}} : {~q, cnt};
    // One revolution: four quadrant steps, wrapping once
    task turn(input bit fwd);
        repeat (4) begin
            @(posedge clk);
            q <= fwd ? q + 2'h1 : q - 2'h1;
            enc_pos_valid <= 1'b1;
        end
        @(posedge clk);
        enc_pos_valid <= 1'b0;
    endtask
endmodule // mtc_enc_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %0t got %h want %h", $time, g, e); end end
module testbench;
    localparam int POS_W = 17;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [3:0]       addr = 4'h0;
    logic [15:0]      wdata = 16'h0;
    logic             wr = 1'b0;
    logic             rd = 1'b0;
    logic             inc = 1'b0;
    logic             sgl = 1'b0;
    logic             bat = 1'b0;
    logic [15:0]      rdata;
    logic [15:0]      turn_count;
    logic             a1;
    logic             a2;
    logic             pv;
    wire  [POS_W-1:0] enc_pos;
    logic [15:0]      exp_cnt = 16'h0;
    logic [15:0]      lim = 16'h000a;
    bit               hold = 1'b0;
    int               err_count = 0;
    int               total_checks = 0;
    int               cycles = 0;
    always #20 clk = ~clk;
    mtc_enc_model #(.POS_W(POS_W)) mtc_enc_model_inst (.clk(clk), .enc_pos(enc_pos), .enc_pos_valid(pv));
    mtc_turn_counter #(.POS_W(POS_W)) mtc_turn_counter_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enc_pos(enc_pos), .enc_pos_valid(pv),
        .enc_is_incremental(inc), .enc_single_turn(sgl), .battery_low(bat), .turn_count(turn_count),
        .encoder_alarm_one(a1), .encoder_alarm_two(a2));
    task finish_test;
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task restart;
        wr_reg(4'h2, 16'h0001);
        repeat (6) @(posedge clk);
    endtask
    // Turns the motor and follows the expected count
    task spin(input bit fwd, input int n);
        repeat (n) begin
            mtc_enc_model_inst.turn(fwd);
            if (hold) exp_cnt = 16'h0;
            else if (lim == 16'h000a || lim == 16'h0) exp_cnt = fwd ? exp_cnt + 16'h1 : exp_cnt - 16'h1;
            else if (fwd) exp_cnt = (exp_cnt == lim - 16'h1) ? 16'h0 : exp_cnt + 16'h1;
            else exp_cnt = (exp_cnt == 16'h0) ? lim - 16'h1 : exp_cnt - 16'h1;
            repeat (3) @(posedge clk);
            #1 `CHK(turn_count, exp_cnt)
        end
    endtask
    // Cuts a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h1, 16'h000a);
        rd_chk(4'h5, 16'h30a9);
        rd_chk(4'h9, 16'h0000);
        rd_chk(4'h3, 16'h0000);
        wr_reg(4'h1, 16'h0003);
        rd_chk(4'h1, 16'h0003);
        spin(1'b1, 3);
        spin(1'b0, 3);
        restart;
        lim = 16'h0003;
        spin(1'b1, 3);
        spin(1'b0, 1);
        rd_chk(4'h4, exp_cnt);
        wr_reg(4'h2, 16'h0004);
        exp_cnt = 16'h0;
        #1 `CHK(turn_count, exp_cnt)
        spin(1'b1, 1);
        sgl <= 1'b1;
        repeat (8) @(posedge clk);
        #1 `CHK(turn_count, 16'h0000)
        hold = 1'b1;
        spin(1'b1, 2);
        sgl <= 1'b0;
        bat <= 1'b1;
        repeat (8) @(posedge clk);
        #1 `CHK(a2, 1'b1)
        bat <= 1'b0;
        repeat (6) @(posedge clk);
        wr_reg(4'h2, 16'h0006);
        #1 `CHK(a2, 1'b0)
        inc <= 1'b1;
        repeat (6) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK(a1, 1'b1)
        wr_reg(4'h0, 16'h0001);
        restart;
        #1 `CHK(a1, 1'b0)
        rd_chk(4'h3, 16'h0014);
        spin(1'b0, 2);
        finish_test;
    end
endmodule // testbench
bind mtc_turn_counter mtc_turn_counter_chk #(.POS_W(POS_W)) mtc_turn_counter_chk_inst (.clk(clk), .rst_b(rst_b),
    .addr(addr), .rd(rd), .rdata(rdata), .enc_pos(enc_pos), .enc_pos_valid(enc_pos_valid),
    .enc_single_turn(enc_single_turn), .battery_low(battery_low), .turn_count(turn_count),
    .encoder_alarm_one(encoder_alarm_one), .encoder_alarm_two(encoder_alarm_two));
`default_nettype wire
